// ---- rtl/ate_engine.sv ----
// acquisition timing engine: strobe generation, start/reference/hold triggers
// assumes tick inputs from the timebase generator, synchronised here like the
// trigger lines arriving asynchronously from pins
//
// Local design decisions: the address map and the strobed register port.
module ate_engine
  import ate_pkg::*;
#(
  parameter int CW = 32 // counter width
)(
  input  wire logic                  clk_sys,       // system clock
  input  wire logic                  rst,           // async reset
  input  wire logic [7:0]            reg_addr,      // register address
  input  wire logic [31:0]           reg_wdata,     // write data
  input  wire logic                  reg_wr,        // write strobe
  input  wire logic                  reg_rd,        // read strobe
  output logic      [31:0]           reg_rdata,     // read data, next cycle
  input  wire logic [7:0]            tb_ticks,      // timebase source ticks
  input  wire logic [ATE_NLINES-1:0] trig_lines,    // async trigger lines
  input  wire logic                  analog_cmp,    // analog comparison event
  output logic                       sample_take,   // take one sample, all ch
  output logic                       buf_write,     // store into buffer
  output logic                       buf_overwrite, // store drops oldest
  output logic                       acq_active,    // acquisition in progress
  output logic [9:0]                 strobe_out,    // trig 0..7, dstarc
  output logic [9:0]                 start_out      // start pulse outputs
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] ctrl;      // control word
  logic [CW-1:0] div;     // divider reload
  logic [CW-1:0] dly;     // start delay ticks
  logic [CW-1:0] pre;     // pretrigger count
  logic [CW-1:0] bsz;     // buffer size
  logic [19:0] route;     // [9:0] strobe, [19:10] start routing

  // sequencer states, read back in the status word in this order
  typedef enum {
    ST_IDLE,
    ST_ARMED,
    ST_DELAY,
    ST_PRE,
    ST_WATCH,
    ST_POST,
    ST_RUN
  } ate_state_t;
  ate_state_t state;

  logic [CW-1:0] cnt;     // sample counter
  logic [CW-1:0] dcnt;    // divider / delay counter
  logic [CW-1:0] stored;  // samples held in buffer
  logic ref_seen;         // reference honoured once
  logic sw_pend;          // software start queued behind arming

  // ------------------------------------------------------------
  // synchronisers for all async inputs
  // ------------------------------------------------------------
  logic [ATE_NLINES-1:0] ln_s1, ln_s2, ln_d;
  logic [7:0] tb_s1, tb_s2, tb_d;
  logic ac_s1, ac_s2, ac_d;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ln_s1 <= '0;
      ln_s2 <= '0;
      ln_d  <= '0;
      tb_s1 <= '0;
      tb_s2 <= '0;
      tb_d  <= '0;
      ac_s1 <= 1'b0;
      ac_s2 <= 1'b0;
      ac_d  <= 1'b0;
    end
    else
    begin
      ln_s1 <= trig_lines;
      ln_s2 <= ln_s1;
      ln_d  <= ln_s2;      // previous level, edge detect only
      tb_s1 <= tb_ticks;
      tb_s2 <= tb_s1;
      tb_d  <= tb_s2;
      ac_s1 <= analog_cmp;
      ac_s2 <= ac_s1;
      ac_d  <= ac_s2;
    end

  // ------------------------------------------------------------
  // decode of fields and edges
  // ------------------------------------------------------------
  wire ate_mode_t mode = ate_mode_t'(ctrl[ATE_CTRL_MODE_LSB +: 2]);
  wire [2:0] tb_sel   = ctrl[ATE_CTRL_TB_SEL_LSB +: 3];
  wire tb_now  = tb_s2[tb_sel];
  wire tb_prev = tb_d[tb_sel];
  // internal sources have no polarity choice
  wire tb_fall_ok = ctrl[ATE_CTRL_TB_FALL] && tb_sel != ATE_TB_100M && tb_sel != ATE_TB_20M;
  wire tb_tick = tb_fall_ok ? (tb_prev & ~tb_now) : (tb_now & ~tb_prev);

  function automatic logic edge_of(input logic now, input logic prv, input logic fall);
    edge_of = fall ? (prv & ~now) : (now & ~prv);
  endfunction : edge_of

  wire [3:0] s_src = ctrl[ATE_CTRL_STRB_SRC +: 4];
  wire [3:0] t_src = ctrl[ATE_CTRL_START_SRC +: 4];
  wire [3:0] r_src = ctrl[ATE_CTRL_REF_SRC +: 4];
  wire [3:0] h_src = ctrl[ATE_CTRL_HOLD_SRC +: 4];
  wire s_ok = s_src < 4'(ATE_NLINES);
  wire t_ok = t_src < 4'(ATE_NLINES);
  wire r_ok = r_src < 4'(ATE_NLINES);
  wire h_ok = h_src < 4'(ATE_NLINES);
  // external strobe edge on chosen line
  wire ext_strb = s_ok && edge_of(ln_s2[s_src], ln_d[s_src], ctrl[ATE_CTRL_STRB_FALL]);
  // hardware start edge
  wire hw_start = t_ok && edge_of(ln_s2[t_src], ln_d[t_src], ctrl[ATE_CTRL_START_FALL]);
  // reference: digital edge or any analog rise
  wire ref_evt = ctrl[ATE_CTRL_REF_ANA] ? (ac_s2 & ~ac_d)
               : (r_ok && edge_of(ln_s2[r_src], ln_d[r_src], ctrl[ATE_CTRL_REF_FALL]));
  // hold is level only
  wire hold = ctrl[ATE_CTRL_HOLD_EN] && h_ok && (ln_s2[h_src] ^ ctrl[ATE_CTRL_HOLD_LOW]);

  wire cmd_wr   = reg_wr && reg_addr == ATE_REG_CMD;
  wire sw_start = cmd_wr && reg_wdata[ATE_CMD_START] && ctrl[ATE_CTRL_START_SW] && mode != ATE_MODE_DEMAND;
  wire sw_stop  = cmd_wr && reg_wdata[ATE_CMD_STOP];
  wire sw_one   = cmd_wr && reg_wdata[ATE_CMD_ONE];
  // a software start fires one cycle after the arming write
  wire start_ev = ctrl[ATE_CTRL_START_SW] ? sw_pend : hw_start;

  wire [CW-1:0] post = bsz - pre;
  wire running = state inside {ST_PRE, ST_WATCH, ST_POST, ST_RUN};
  wire waiting = state == ST_IDLE || state == ST_ARMED;

  // internal divider tick, paused by hold
  wire int_strb = !ctrl[ATE_CTRL_STRB_EXT] && running && tb_tick && !hold && dcnt == '0;
  // strobe gated by acquisition
  wire strb = running && (ctrl[ATE_CTRL_STRB_EXT] ? ext_strb : int_strb);
  wire demand = mode == ATE_MODE_DEMAND && sw_one;
  wire last_post = strb && cnt == CW'(1);
  wire armed_go = state == ST_ARMED && start_ev;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ctrl  <= ATE_CTRL_RST;
      div   <= CW'(ATE_DIV_RST);
      dly   <= CW'(ATE_DELAY_RST);
      pre   <= CW'(ATE_PRE_RST);
      bsz   <= CW'(ATE_BUF_RST);
      route <= '0;
    end
    else if (reg_wr)
      case (reg_addr)
        ATE_REG_CTRL:  ctrl  <= reg_wdata;
        ATE_REG_DIV:   div   <= CW'(reg_wdata);
        ATE_REG_DELAY: dly   <= CW'(reg_wdata);
        ATE_REG_PRE:   pre   <= CW'(reg_wdata);
        ATE_REG_BUF:   bsz   <= CW'(reg_wdata);
        ATE_REG_ROUTE: route <= reg_wdata[19:0];
        default: ;
      endcase

  // ------------------------------------------------------------
  // software start: arm now, start on the next cycle
  // ------------------------------------------------------------
  // the arming write moves idle to armed, so the start itself waits one
  // cycle; a stop in the same write cancels the queued start
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      sw_pend <= 1'b0;
    else
      sw_pend <= sw_start && state == ST_IDLE && !sw_stop;

  // ------------------------------------------------------------
  // acquisition sequencer
  // ------------------------------------------------------------
  // a stop wins over every state; the counters are left as they are
  // and reloaded on the next start, so a stale count never leaks
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      state    <= ST_IDLE;
      cnt      <= '0;
      dcnt     <= '0;
      stored   <= '0;
      ref_seen <= 1'b0;
    end
    else if (sw_stop)
      state <= ST_IDLE;
    else
      case (state)
        // waiting for an arm command
        ST_IDLE:
        begin
          if (cmd_wr && reg_wdata[ATE_CMD_START] && mode != ATE_MODE_DEMAND)
            state <= ST_ARMED;
        end
        // armed, waiting for the start event
        ST_ARMED:
        begin
          if (start_ev)
          begin
            state    <= ST_DELAY;
            dcnt     <= dly;
            stored   <= '0;
            ref_seen <= 1'b0;
            cnt <= (mode == ATE_MODE_REF) ? pre : bsz;
          end
        end
        // start delay in timebase ticks, skipped for an external strobe
        ST_DELAY:
        begin
          if (ctrl[ATE_CTRL_STRB_EXT] || dcnt == '0)
            state <= (mode == ATE_MODE_REF) ? (pre == '0 ? ST_WATCH : ST_PRE)
                   : (mode == ATE_MODE_CONT ? ST_RUN : ST_POST);
          else if (tb_tick)
            dcnt <= dcnt - CW'(1);
        end
        default:
        begin
          if (tb_tick && !hold)
            dcnt <= (dcnt == '0) ? div - CW'(1) : dcnt - CW'(1);
          if (strb && stored != bsz)
            stored <= stored + CW'(1);
          case (state)
            // pretrigger samples, reference ignored here
            ST_PRE:
              if (strb)
              begin
                cnt <= cnt - CW'(1);
                if (cnt == CW'(1))
                  state <= ST_WATCH;
              end
            // looking for the reference while the buffer wraps
            ST_WATCH:
              if (ref_evt && !ref_seen)
              begin
                ref_seen <= 1'b1;
                cnt      <= post;
                state    <= ST_POST;
              end
            // posttrigger or finite samples
            ST_POST:
              if (strb)
              begin
                cnt <= cnt - CW'(1);
                if (cnt == CW'(1))
                  state <= ctrl[ATE_CTRL_RETRIG] && mode != ATE_MODE_REF ? ST_ARMED : ST_IDLE;
              end
            default: ;
          endcase
          // start edges during generation are dropped
        end
      endcase

  // ------------------------------------------------------------
  // outputs and read-back
  // ------------------------------------------------------------
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      ATE_REG_CTRL:   next_rdata = ctrl;
      ATE_REG_DIV:    next_rdata = 32'(div);
      ATE_REG_DELAY:  next_rdata = 32'(dly);
      ATE_REG_PRE:    next_rdata = 32'(pre);
      ATE_REG_BUF:    next_rdata = 32'(bsz);
      ATE_REG_STATUS: next_rdata = {28'h0, ref_seen, 3'(state)};
      ATE_REG_COUNT:  next_rdata = 32'(cnt);
      ATE_REG_ROUTE:  next_rdata = {12'h000, route};
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // every output is a flop; pulses last exactly one cycle
  wire take = strb || demand;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      reg_rdata     <= '0;
      sample_take   <= 1'b0;
      buf_write     <= 1'b0;
      buf_overwrite <= 1'b0;
      acq_active    <= 1'b0;
      strobe_out    <= '0;
      start_out     <= '0;
    end
    else
    begin
      reg_rdata     <= reg_rd ? next_rdata : 32'h0000_0000;
      sample_take   <= take;
      buf_write     <= take;
      buf_overwrite <= strb && stored == bsz && state == ST_WATCH;
      acq_active    <= running;
      strobe_out    <= take ? route[9:0] : 10'h000;
      start_out     <= armed_go ? route[19:10] : 10'h000;
    end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  strobe_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    sample_take |-> $past(running) || $past(demand)) else $error("sample outside acquisition");
  strobe_route_a: assert property (@(posedge clk_sys) disable iff (rst)
    sample_take |-> strobe_out == $past(route[9:0])) else $error("strobe output mismatch");
  start_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    armed_go |=> start_out == $past(route[19:10])) else $error("start pulse missing");
  retrig_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_POST && start_ev && !last_post && !sw_stop) |=> state == ST_POST)
    else $error("start taken mid sequence");
  ref_early_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_PRE && ref_evt && !sw_stop) |=> state != ST_POST) else $error("early reference honoured");
  post_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state == ST_WATCH && ref_evt && !ref_seen && !sw_stop) |=> cnt == $past(post))
    else $error("posttrigger count wrong");
  hold_pause_a: assert property (@(posedge clk_sys) disable iff (rst)
    (hold && !ctrl[ATE_CTRL_STRB_EXT] && !demand) |=> !sample_take) else $error("strobe during hold");
  delay_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    armed_go && !sw_stop |=> state == ST_DELAY && dcnt == $past(dly)) else $error("delay not loaded");
  stop_end_a: assert property (@(posedge clk_sys) disable iff (rst)
    sw_stop |=> state == ST_IDLE ##1 !acq_active) else $error("stop ignored");
  sw_start_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sw_start && state == ST_IDLE && !sw_stop) |=> armed_go) else $error("software start not taken");
  demand_take_a: assert property (@(posedge clk_sys) disable iff (rst)
    demand |=> sample_take) else $error("on-demand strobe lost");
  over_watch_a: assert property (@(posedge clk_sys) disable iff (rst)
    buf_overwrite |-> $past(state == ST_WATCH)) else $error("overwrite outside watch");
  cov_demand_c: cover property (@(posedge clk_sys) demand);
  cov_ref_c:    cover property (@(posedge clk_sys) state == ST_WATCH ##1 state == ST_POST);
  cov_retrig_c: cover property (@(posedge clk_sys) state == ST_POST ##1 state == ST_ARMED);
  cov_over_c:   cover property (@(posedge clk_sys) buf_overwrite);
  cov_hold_c:   cover property (@(posedge clk_sys) running && hold);

endmodule : ate_engine

// ---- shared/ate_pkg.sv ----
// package for the acquisition timing engine: register map, fields, modes
// assumes a single clock domain and a plain strobe register port
package ate_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ATE_REG_CTRL    = 8'h00; // mode, edges, sources
  localparam logic [7:0] ATE_REG_CMD     = 8'h04; // command pulses
  localparam logic [7:0] ATE_REG_DIV     = 8'h08; // strobe divider
  localparam logic [7:0] ATE_REG_DELAY   = 8'h0C; // start to first strobe
  localparam logic [7:0] ATE_REG_PRE     = 8'h10; // pretrigger count
  localparam logic [7:0] ATE_REG_BUF     = 8'h14; // finite buffer size
  localparam logic [7:0] ATE_REG_STATUS  = 8'h18; // engine state
  localparam logic [7:0] ATE_REG_COUNT   = 8'h1C; // sample counter
  localparam logic [7:0] ATE_REG_ROUTE   = 8'h20; // output routing

  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int ATE_CTRL_MODE_LSB   = 0;  // 2 bits mode
  localparam int ATE_CTRL_RETRIG     = 2;  // retriggerable
  localparam int ATE_CTRL_STRB_EXT   = 3;  // external strobe
  localparam int ATE_CTRL_STRB_FALL  = 4;  // sample on falling edge
  localparam int ATE_CTRL_START_SW   = 5;  // software start trigger
  localparam int ATE_CTRL_START_FALL = 6;
  localparam int ATE_CTRL_REF_ANA    = 7;  // analog reference source
  localparam int ATE_CTRL_REF_FALL   = 8;
  localparam int ATE_CTRL_HOLD_EN    = 9;
  localparam int ATE_CTRL_HOLD_LOW   = 10; // hold active low
  localparam int ATE_CTRL_TB_FALL    = 11; // timebase falling edge
  localparam int ATE_CTRL_TB_SEL_LSB = 12; // 3 bits timebase source
  localparam int ATE_CTRL_STRB_SRC   = 16; // 4 bits strobe source
  localparam int ATE_CTRL_START_SRC  = 20; // 4 bits start source
  localparam int ATE_CTRL_REF_SRC    = 24; // 4 bits reference source
  localparam int ATE_CTRL_HOLD_SRC   = 28; // 4 bits hold source

  // command bits
  localparam int ATE_CMD_START = 0; // arm / software start
  localparam int ATE_CMD_STOP  = 1; // software stop
  localparam int ATE_CMD_ONE   = 2; // on-demand single strobe

  // reset values
  localparam logic [31:0] ATE_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ATE_DIV_RST   = 32'h0000_0064;
  localparam logic [31:0] ATE_DELAY_RST = 32'h0000_0002; // two timebase ticks
  localparam logic [31:0] ATE_PRE_RST   = 32'h0000_0000;
  localparam logic [31:0] ATE_BUF_RST   = 32'h0000_0010;

  // trigger line count: 2 front inputs, 8 backplane, star, dstar a/b
  localparam int ATE_NLINES = 13;

  // timebase source codes: internal 100m/20m carry no polarity
  localparam logic [2:0] ATE_TB_100M = 3'h0;
  localparam logic [2:0] ATE_TB_20M  = 3'h1;

  // acquisition modes
  typedef enum logic [1:0] {
    ATE_MODE_FINITE,
    ATE_MODE_CONT,
    ATE_MODE_REF,
    ATE_MODE_DEMAND
  } ate_mode_t;

endpackage : ate_pkg

// ---- verification/ate_far_side.sv ----
// far-side model: timebase levels, chassis and front trigger lines, comparison
// assumes the bench requests pulses with one-cycle strobes on clk_sys
module ate_far_side (
  input  wire logic        clk_sys,    // bench clock
  input  wire logic        pulse_req,  // one-cycle pulse request
  input  wire logic [3:0]  pulse_idx,  // line to pulse, 15 = comparison
  input  wire logic        hold_lvl,   // level on hold line 4
  input  wire logic        strb_run,   // run external strobe on line 5
  output logic      [7:0]  tb_ticks,   // timebase source levels
  output logic      [12:0] trig_lines, // trigger lines, idle low
  output logic             analog_cmp  // comparison event level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt; // free-running timebase divider
  logic [2:0] wid; // remaining pulse width
  logic [3:0] idx; // line being pulsed

  initial
  begin
    cnt = 8'h00;
    wid = 3'h0;
    idx = 4'h0;
  end

  // timebase moves on the falling edge, unrelated to the sampling edge
  always @(negedge clk_sys) cnt <= cnt + 8'h01;

  // pulses stay six cycles so the design's synchronisers see them
  always @(posedge clk_sys)
  begin
    if (pulse_req)
    begin
      wid <= 3'h6;
      idx <= pulse_idx;
    end
    else if (wid != 3'h0)
      wid <= wid - 3'h1;
  end

  // line levels: pulses, hold level, free external strobe
  always_comb
  begin
    trig_lines = 13'h0000;
    if (wid != 3'h0 && idx < 4'hD) trig_lines[idx] = 1'b1;
    trig_lines[4] = hold_lvl;
    trig_lines[5] = strb_run & cnt[3];
  end

  assign analog_cmp = (wid != 3'h0) && (idx == 4'hF);
  assign tb_ticks   = cnt;
endmodule : ate_far_side

// ---- verification/tb_top.sv ----
// bench for the acquisition timing engine: register tasks and scenarios
// assumes the far-side model supplies timebase, trigger lines and comparison
module tb_top import ate_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, rst, reg_wr, reg_rd, pulse_req, hold_lvl, strb_run;
  logic [7:0]  reg_addr, tb_ticks;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0]  pulse_idx;
  logic [12:0] trig_lines;
  logic        analog_cmp, sample_take, buf_write, buf_overwrite, acq_active;
  logic [9:0]  strobe_out, start_out;
  int          error_cnt, compares, cyc, n_smp, n_wr, n_ovw, n_sto, n_sta;

  ate_engine uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tb_ticks(tb_ticks),
    .trig_lines(trig_lines), .analog_cmp(analog_cmp), .sample_take(sample_take),
    .buf_write(buf_write), .buf_overwrite(buf_overwrite), .acq_active(acq_active),
    .strobe_out(strobe_out), .start_out(start_out));
  ate_far_side far (.clk_sys(clk_sys), .pulse_req(pulse_req), .pulse_idx(pulse_idx),
    .hold_lvl(hold_lvl), .strb_run(strb_run), .tb_ticks(tb_ticks),
    .trig_lines(trig_lines), .analog_cmp(analog_cmp));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : chk_reg
  task automatic clr();
    @(negedge clk_sys);
    n_smp = 0; n_wr = 0; n_ovw = 0; n_sto = 0; n_sta = 0;
  endtask : clr
  task automatic fire(input logic [3:0] i);
    @(posedge clk_sys);
    pulse_idx <= i;
    pulse_req <= 1'b1;
    @(posedge clk_sys);
    pulse_req <= 1'b0;
  endtask : fire
  task automatic wait_smp(input int n);
    for (int i = 0; i < 4000 && n_smp < n; i++) @(posedge clk_sys);
  endtask : wait_smp
  task automatic wait_idle();
    for (int i = 0; i < 4000 && acq_active !== 1'b0; i++) @(posedge clk_sys);
    repeat (60) @(posedge clk_sys);
  endtask : wait_idle
  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // output pulse counters, sample/store pairing, cycle ceiling
  always @(posedge clk_sys)
  begin
    cyc++;
    if (sample_take === 1'b1) n_smp++;
    if (buf_write === 1'b1) n_wr++;
    if (buf_overwrite === 1'b1) n_ovw++;
    if (strobe_out[0] === 1'b1) n_sto++;
    if (start_out[0] === 1'b1) n_sta++;
    if (sample_take !== 1'b0 || buf_write !== 1'b0) chk({31'h0, sample_take}, {31'h0, buf_write});
    if (cyc == 80000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    {rst, reg_wr, reg_rd, pulse_req, hold_lvl, strb_run} = 6'b100000;
    reg_addr = 8'h00; reg_wdata = 32'h0; pulse_idx = 4'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // reset values, read-only status, unmapped place
    chk_reg(ATE_REG_CTRL, ATE_CTRL_RST);
    chk_reg(ATE_REG_DIV, ATE_DIV_RST);
    chk_reg(ATE_REG_DELAY, ATE_DELAY_RST);
    chk_reg(ATE_REG_PRE, ATE_PRE_RST);
    chk_reg(ATE_REG_BUF, ATE_BUF_RST);
    wr(ATE_REG_STATUS, 32'hFFFF_FFFF);
    chk_reg(ATE_REG_STATUS, 32'h0000_0000);
    wr(8'h30, 32'h1234_5678);
    chk_reg(8'h30, 32'h0000_0000);
    $display("test reset done");
    // finite, internal strobe, software start
    wr(ATE_REG_ROUTE, 32'h0000_0401);
    wr(ATE_REG_DIV, 32'h0000_0004);
    wr(ATE_REG_BUF, 32'h0000_0004);
    wr(ATE_REG_CTRL, 32'h0000_0020);
    clr();
    wr(ATE_REG_CMD, 32'h0000_0001);
    wait_smp(4);
    wait_idle();
    chk(32'(n_smp), 32'h4);
    chk(32'(n_sto), 32'h4);
    chk(32'(n_sta), 32'h1);
    chk({31'h0, acq_active}, 32'h0);
    $display("test finite done");
    // retriggerable, hardware start on backplane line 0
    wr(ATE_REG_CTRL, 32'h0020_0004);
    clr();
    wr(ATE_REG_CMD, 32'h0000_0001);
    fire(4'h2);
    wait_smp(2);
    fire(4'h2);
    wait_smp(4);
    repeat (300) @(posedge clk_sys);
    chk(32'(n_smp), 32'h4);
    chk(32'(n_sta), 32'h1);
    fire(4'h2);
    wait_smp(8);
    repeat (300) @(posedge clk_sys);
    chk(32'(n_smp), 32'h8);
    wr(ATE_REG_CMD, 32'h0000_0002);
    $display("test retrigger done");
    // external strobe on line 5, both sampling edges
    for (int p = 0; p < 2; p++)
    begin
      wr(ATE_REG_CTRL, 32'h0005_0028 | (32'(p) << 4));
      strb_run <= 1'b1;
      clr();
      repeat (100) @(posedge clk_sys);
      chk(32'(n_smp), 32'h0);
      wr(ATE_REG_CMD, 32'h0000_0001);
      wait_smp(4);
      wait_idle();
      chk(32'(n_smp), 32'h4);
      strb_run <= 1'b0;
    end
    $display("test external done");
    // on-demand single strobes
    wr(ATE_REG_CTRL, 32'h0000_0023);
    clr();
    wr(ATE_REG_CMD, 32'h0000_0001);
    repeat (30) @(posedge clk_sys);
    wr(ATE_REG_CMD, 32'h0000_0004);
    repeat (30) @(posedge clk_sys);
    wr(ATE_REG_CMD, 32'h0000_0004);
    repeat (30) @(posedge clk_sys);
    chk(32'(n_smp), 32'h2);
    wr(ATE_REG_CMD, 32'h0000_0002);
    $display("test on_demand done");
    // reference on line 3: early event, circular fill, post count, second event
    wr(ATE_REG_DIV, 32'h0000_0010);
    wr(ATE_REG_PRE, 32'h0000_0004);
    wr(ATE_REG_BUF, 32'h0000_0008);
    wr(ATE_REG_CTRL, 32'h0300_0022);
    clr();
    wr(ATE_REG_CMD, 32'h0000_0001);
    fire(4'h3);
    wait_smp(6);
    rd(ATE_REG_STATUS, d);
    chk({31'h0, d[3]}, 32'h0);
    for (int i = 0; i < 4000 && n_ovw == 0; i++) @(posedge clk_sys);
    chk({31'h0, n_ovw > 0}, 32'h1);
    for (int i = 0; i < 400 && sample_take !== 1'b1; i++) @(posedge clk_sys);
    clr();
    fire(4'h3);
    wait_smp(1);
    fire(4'h3);
    wait_smp(4);
    wait_idle();
    chk(32'(n_wr), 32'h4);
    $display("test reference done");
    // continuous with hold, both active levels, software stop
    for (int p = 0; p < 2; p++)
    begin
      wr(ATE_REG_CTRL, 32'h4000_0221 | (32'(p) << 10));
      hold_lvl <= p[0];
      wr(ATE_REG_CMD, 32'h0000_0001);
      repeat (100) @(posedge clk_sys);
      hold_lvl <= ~p[0];
      repeat (20) @(posedge clk_sys);
      clr();
      repeat (300) @(posedge clk_sys);
      chk(32'(n_smp), 32'h0);
      hold_lvl <= p[0];
      repeat (300) @(posedge clk_sys);
      chk({31'h0, n_smp > 0}, 32'h1);
      wr(ATE_REG_CMD, 32'h0000_0002);
      repeat (40) @(posedge clk_sys);
      chk({31'h0, acq_active}, 32'h0);
    end
    $display("test hold done");
    test_done();
  end
endmodule : tb_top
